/* File: rtl/sc_block_pkg.sv */
package sc_block_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int NUM_INSTANCES = 4;
    localparam int APB_ADDR_W = 10;
    localparam int APB_DATA_W = 32;
    localparam int CAP_UNITS = 31;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices, byte address is four times the index
    localparam logic [7:0] SC_A10_BRANCH_SELECT_CTRL_IDX = 8'h81;
    localparam logic [7:0] SC_A12_BRANCH_SELECT_CTRL_IDX = 8'h89;
    localparam logic [7:0] SC_A21_BRANCH_SELECT_CTRL_IDX = 8'h95;
    localparam logic [7:0] SC_A23_BRANCH_SELECT_CTRL_IDX = 8'h9D;
    localparam logic [7:0] SELECT_IDX [NUM_INSTANCES] = '{
        SC_A10_BRANCH_SELECT_CTRL_IDX, SC_A12_BRANCH_SELECT_CTRL_IDX,
        SC_A21_BRANCH_SELECT_CTRL_IDX, SC_A23_BRANCH_SELECT_CTRL_IDX};
    // Bus and nulling control, one per instance
    localparam logic [7:0] BUS_IDX [NUM_INSTANCES] = '{8'h82, 8'h8A, 8'h96, 8'h9E};
    // Phase steering control, one per instance (only the swap bit lives here)
    localparam logic [7:0] PHASE_IDX [NUM_INSTANCES] = '{8'h80, 8'h88, 8'h94, 8'h9C};
    // Global sample-and-hold bypass
    localparam logic [7:0] HOLD_BYPASS_IDX = 8'h63;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions and reset values
    localparam int SEL_COMMON_BIT = 7;
    localparam int SEL_LSB = 5;
    localparam int CAP_MSB = 4;
    localparam int DRIVE_BIT = 7;
    localparam int CMP_BIT = 6;
    localparam int NULL_BIT = 5;
    localparam int SWAP_BIT = 6;
    localparam int HOLD_BIT = 6;
    localparam logic [7:0] REG_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Column phase timing, counter states of one column period
    localparam int PHASE_CNT_W = 3;
    localparam logic [PHASE_CNT_W-1:0] P1_FIRST = 3'h1;
    localparam logic [PHASE_CNT_W-1:0] P1_LATE = 3'h2;
    localparam logic [PHASE_CNT_W-1:0] P1_LAST = 3'h3;
    localparam logic [PHASE_CNT_W-1:0] P2_FIRST = 3'h5;
    localparam logic [PHASE_CNT_W-1:0] P2_LATE = 3'h6;
    localparam logic [PHASE_CNT_W-1:0] P2_LAST = 3'h7;

    ////////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [2:0] {
        REG_NONE = 3'b000,
        REG_PHASE = 3'b001,
        REG_SELECT = 3'b010,
        REG_BUS = 3'b011,
        REG_HOLD = 3'b100
    } reg_kind_e;

    typedef struct packed {
        reg_kind_e kind;
        logic [1:0] inst;
    } reg_hit_s;

    typedef struct packed {
        logic phase_one;
        logic phase_two;
        logic common_source;
        logic [1:0] a_source;
        logic [CAP_UNITS-1:0] b_cap_en;
        logic [CAP_UNITS-1:0] c_cap_en;
        logic column_bus_connect;
        logic comparator_drive;
        logic comparator_value;
        logic feedback_short;
        logic branch_to_ground;
        logic branch_to_opamp;
        logic offset_null_state;
    } switch_ctrl_s;

    // Binary size to unit-capacitor enables, lowest units first
    function automatic logic [CAP_UNITS-1:0] cap_units(input logic [CAP_MSB:0] size);
        logic [CAP_UNITS-1:0] mask;
        mask = '0;
        for (int i = 0; i < CAP_UNITS; i++) begin
            mask[i] = (5'(i) < size);
        end
        return mask;
    endfunction

endpackage

/* File: rtl/sc_block_switch_control.sv */
`timescale 1ns/100ps
`default_nettype none
module sc_block_switch_control
    import sc_block_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic [APB_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [APB_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_INSTANCES-1:0] comparator_result,
    output switch_ctrl_s [NUM_INSTANCES-1:0] sw_ctrl
);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    logic [1:0] rst_sync;
    logic rst_n;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode, only aligned words of the map hit
    function automatic reg_hit_s decode_addr(input logic [APB_ADDR_W-1:0] addr);
        reg_hit_s hit;
        hit.kind = REG_NONE;
        hit.inst = 2'b00;
        for (int i = 0; i < NUM_INSTANCES; i++) begin
            if (addr == {SELECT_IDX[i], 2'b00}) begin
                hit.kind = REG_SELECT;
                hit.inst = 2'(i);
            end
            if (addr == {BUS_IDX[i], 2'b00}) begin
                hit.kind = REG_BUS;
                hit.inst = 2'(i);
            end
            if (addr == {PHASE_IDX[i], 2'b00}) begin
                hit.kind = REG_PHASE;
                hit.inst = 2'(i);
            end
        end
        if (addr == {HOLD_BYPASS_IDX, 2'b00}) begin
            hit.kind = REG_HOLD;
        end
        return hit;
    endfunction

    reg_hit_s hit;
    logic wr_access;
    assign hit = decode_addr(paddr);
    // Write lands only on the completing access edge
    assign wr_access = psel && penable && pready && pwrite && pstrb[0];

    ////////////////////////////////////////////////////////////////////////////////
    // Control registers
    logic [7:0] select_reg [NUM_INSTANCES];
    logic [7:0] bus_reg [NUM_INSTANCES];
    logic [NUM_INSTANCES-1:0] phase_swap;
    logic hold_bypass;
    logic [7:0] next_select_reg [NUM_INSTANCES];
    logic [7:0] next_bus_reg [NUM_INSTANCES];
    logic [NUM_INSTANCES-1:0] next_phase_swap;
    logic next_hold_bypass;

    // Software writes; only the pstrb[0] byte lane is used
    always_comb begin
        next_select_reg = select_reg;
        next_bus_reg = bus_reg;
        next_phase_swap = phase_swap;
        next_hold_bypass = hold_bypass;
        if (wr_access) begin
            case (hit.kind)
                REG_SELECT: next_select_reg[hit.inst] = pwdata[7:0];
                REG_BUS: next_bus_reg[hit.inst] = pwdata[7:0];
                REG_PHASE: next_phase_swap[hit.inst] = pwdata[SWAP_BIT];
                REG_HOLD: next_hold_bypass = pwdata[HOLD_BIT];
                default: next_hold_bypass = hold_bypass;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_INSTANCES; i++) begin
                select_reg[i] <= REG_RESET;
                bus_reg[i] <= REG_RESET;
            end
            phase_swap <= '0;
            hold_bypass <= 1'b0;
        end else if (ce) begin
            select_reg <= next_select_reg;
            bus_reg <= next_bus_reg;
            phase_swap <= next_phase_swap;
            hold_bypass <= next_hold_bypass;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB answer: one access cycle, data prepared in the setup cycle
    logic [APB_DATA_W-1:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    always_comb begin
        next_pready = psel && !penable;
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (psel && !penable) begin
            next_prdata = '0;
            next_pslverr = (hit.kind == REG_NONE);
            if (!pwrite) begin
                case (hit.kind)
                    REG_SELECT: next_prdata[7:0] = select_reg[hit.inst];
                    REG_BUS: next_prdata[7:0] = bus_reg[hit.inst];
                    REG_PHASE: next_prdata[SWAP_BIT] = phase_swap[hit.inst];
                    REG_HOLD: next_prdata[HOLD_BIT] = hold_bypass;
                    default: next_prdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Column period counter; states 0 and 4 are dead bands between phases
    logic [PHASE_CNT_W-1:0] phase_cnt;
    logic [PHASE_CNT_W-1:0] next_phase_cnt;

    always_comb begin
        next_phase_cnt = phase_cnt + 3'h1;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase_cnt <= '0;
        end else if (ce) begin
            phase_cnt <= next_phase_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Comparator inputs come from analog, so two flops first
    logic [NUM_INSTANCES-1:0] cmp_meta;
    logic [NUM_INSTANCES-1:0] cmp_sync;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_meta <= '0;
            cmp_sync <= '0;
        end else if (ce) begin
            cmp_meta <= comparator_result;
            cmp_sync <= cmp_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Switch enables per instance
    logic [NUM_INSTANCES-1:0] cmp_hold;
    logic [NUM_INSTANCES-1:0] next_cmp_hold;
    switch_ctrl_s [NUM_INSTANCES-1:0] next_sw;

    always_comb begin
        logic ph1_ext;
        logic ph2_ext;
        logic int_p1;
        logic int_p2;
        logic int_late2;
        logic int_rise1;
        logic nulling;
        ph1_ext = (phase_cnt >= P1_FIRST) && (phase_cnt <= P1_LAST);
        ph2_ext = (phase_cnt >= P2_FIRST) && (phase_cnt <= P2_LAST);
        int_p1 = 1'b0;
        int_p2 = 1'b0;
        int_late2 = 1'b0;
        int_rise1 = 1'b0;
        nulling = 1'b0;
        next_cmp_hold = cmp_hold;
        next_sw = '0;
        for (int i = 0; i < NUM_INSTANCES; i++) begin
            // Swap exchanges which external phase drives the block
            int_p1 = phase_swap[i] ? ph2_ext : ph1_ext;
            int_p2 = phase_swap[i] ? ph1_ext : ph2_ext;
            int_late2 = phase_swap[i] ? (phase_cnt >= P1_LATE && ph1_ext)
                                      : (phase_cnt >= P2_LATE);
            int_rise1 = (phase_cnt == (phase_swap[i] ? P2_FIRST : P1_FIRST));
            nulling = bus_reg[i][NULL_BIT];
            next_sw[i].phase_one = int_p1;
            next_sw[i].phase_two = int_p2;
            // Common source overrides the low select bits, codes 5-7 included
            next_sw[i].common_source = select_reg[i][SEL_COMMON_BIT];
            next_sw[i].a_source = select_reg[i][SEL_COMMON_BIT] ? 2'b00
                                : select_reg[i][SEL_LSB+1:SEL_LSB];
            next_sw[i].b_cap_en = cap_units(select_reg[i][CAP_MSB:0]);
            next_sw[i].c_cap_en = cap_units(bus_reg[i][CAP_MSB:0]);
            // Late-phase gating, off when swapped or bypassed, keeps the bus clear of settling glitches
            if (!bus_reg[i][DRIVE_BIT]) begin
                next_sw[i].column_bus_connect = 1'b0;
            end else if (phase_swap[i]) begin
                next_sw[i].column_bus_connect = 1'b1;
            end else if (hold_bypass) begin
                next_sw[i].column_bus_connect = int_p2;
            end else begin
                next_sw[i].column_bus_connect = int_late2;
            end
            // Latch updates only at internal phase one rise
            if (int_rise1) begin
                next_cmp_hold[i] = cmp_sync[i];
            end
            next_sw[i].comparator_drive = bus_reg[i][CMP_BIT];
            // Data forced low when released so a wired bus idles low
            next_sw[i].comparator_value = next_cmp_hold[i] && bus_reg[i][CMP_BIT];
            next_sw[i].feedback_short = nulling && int_p1;
            next_sw[i].branch_to_ground = nulling && int_p1;
            next_sw[i].branch_to_opamp = nulling ? int_p2 : 1'b1;
            next_sw[i].offset_null_state = nulling;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_hold <= '0;
            sw_ctrl <= '0;
        end else if (ce) begin
            cmp_hold <= next_cmp_hold;
            sw_ctrl <= next_sw;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence apb_setup;
        psel && !penable && ce;
    endsequence

    sequence select_a10_write;
        wr_access && ce && (paddr == {SC_A10_BRANCH_SELECT_CTRL_IDX, 2'b00});
    endsequence

    a_apb_answer: assert property (apb_setup |=> pready)
        else $error("no answer after setup");
    a_select_decode: assert property (
        select_a10_write |=> select_reg[0] == $past(pwdata[7:0]))
        else $error("select register write lost");

    for (genvar g = 0; g < NUM_INSTANCES; g++) begin : gen_chk
        sequence in_phase_two;
            sw_ctrl[g].phase_two ##1 sw_ctrl[g].phase_two && $stable(sw_ctrl[g].comparator_drive);
        endsequence

        a_drive_float: assert property (
            $past(ce) && !$past(bus_reg[g][DRIVE_BIT]) |-> !sw_ctrl[g].column_bus_connect)
            else $error("column bus driven while disabled");
        a_drive_gated: assert property (
            $past(ce) && $past(bus_reg[g][DRIVE_BIT]) && !$past(phase_swap[g])
            && !$past(hold_bypass)
            |-> sw_ctrl[g].column_bus_connect == ($past(phase_cnt) >= P2_LATE))
            else $error("column bus not gated to late phase two");
        a_drive_cont: assert property (
            $past(ce) && $past(bus_reg[g][DRIVE_BIT]) && $past(phase_swap[g])
            |-> sw_ctrl[g].column_bus_connect)
            else $error("column bus dropped while swapped");
        a_hold_whole: assert property (
            $past(ce) && $past(bus_reg[g][DRIVE_BIT]) && $past(hold_bypass)
            && !$past(phase_swap[g])
            |-> sw_ctrl[g].column_bus_connect == sw_ctrl[g].phase_two)
            else $error("bypass does not cover phase two");
        a_cmp_drive: assert property (
            $past(ce) |-> sw_ctrl[g].comparator_drive == $past(bus_reg[g][CMP_BIT]))
            else $error("comparator drive mismatch");
        a_cmp_stable: assert property (
            in_phase_two |-> $stable(sw_ctrl[g].comparator_value))
            else $error("comparator value moved in phase two");
        a_phase_excl: assert property (
            !(sw_ctrl[g].phase_one && sw_ctrl[g].phase_two))
            else $error("phases overlap");
        a_null_short: assert property (
            $past(ce) && $past(bus_reg[g][NULL_BIT])
            |-> sw_ctrl[g].feedback_short == sw_ctrl[g].phase_one
            && sw_ctrl[g].branch_to_opamp == sw_ctrl[g].phase_two)
            else $error("nulling switches off phase");
        a_null_open: assert property (
            // Outputs still sit at their reset zeros one edge after release
            $past(rst_n) && $past(ce) && !$past(bus_reg[g][NULL_BIT])
            |-> !sw_ctrl[g].feedback_short && sw_ctrl[g].branch_to_opamp)
            else $error("nulling switches active while off");
        a_common_src: assert property (
            $past(ce) && $past(select_reg[g][SEL_COMMON_BIT])
            |-> sw_ctrl[g].common_source && sw_ctrl[g].a_source == 2'b00)
            else $error("common source not forced");
        a_cap_count: assert property (
            $past(ce) |-> $countones(sw_ctrl[g].b_cap_en) == int'($past(select_reg[g][CAP_MSB:0]))
            && $countones(sw_ctrl[g].c_cap_en) == int'($past(bus_reg[g][CAP_MSB:0])))
            else $error("capacitor unit count wrong");
    end

endmodule
`default_nettype wire

/* File: tb/sc_analog_array_model.sv */
`timescale 1ns/100ps
`default_nettype none
module sc_analog_array_model
    import sc_block_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire switch_ctrl_s [NUM_INSTANCES-1:0] sw_ctrl,
    output logic [NUM_INSTANCES-1:0] comparator_result,
    output logic comparator_bus
);
    logic [3:0] tick;

    ////////////////////////////////////////////////////////////////////////////////
    // Comparator levels step every third cycle, off the column period, so
    // latched samples change between periods for some instances only
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tick <= 4'h0;
            comparator_result <= 4'h5;
        end else begin
            tick <= (tick == 4'h2) ? 4'h0 : tick + 4'h1;
            if (tick == 4'h2) begin
                comparator_result <= {comparator_result[2:0], ~comparator_result[3]};
            end
        end
    end

    // Column comparator bus, wired-or of enabled drivers over a pull-down
    always_comb begin
        comparator_bus = 1'b0;
        for (int i = 0; i < NUM_INSTANCES; i++) begin
            if (sw_ctrl[i].comparator_drive) begin
                comparator_bus = comparator_bus | sw_ctrl[i].comparator_value;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/sc_block_switch_control_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module sc_block_switch_control_bench
    import sc_block_pkg::*;
;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] comparator_result;
    switch_ctrl_s [3:0] sw_ctrl;
    logic comparator_bus;
    logic [31:0] rd;
    logic err;
    int err_count = 0;
    int checked = 0;
    logic [7:0] bus_tab [4] = '{8'h00, 8'hff, 8'hd1, 8'ha5};

    sc_block_switch_control dut (.mclk(mclk), .reset_n(reset_n), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .comparator_result(comparator_result), .sw_ctrl(sw_ctrl));
    sc_analog_array_model array_model (.mclk(mclk), .reset_n(reset_n), .sw_ctrl(sw_ctrl),
        .comparator_result(comparator_result), .comparator_bus(comparator_bus));

    always #25 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////////
    // Checking and bus helpers
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [30:0] thermo(input int n);
        logic [31:0] m;
        m = (32'h0000_0001 << n) - 32'h0000_0001;
        return m[30:0];
    endfunction

    // Request held until pready is seen at an edge, released only after it
    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 16) begin
            n++;
            @(posedge mclk);
        end
        if (n == 16) err_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h00_0000, d});
        chk("write error", 32'h0, err);
    endtask

    task automatic rdchk(input string name, input logic [9:0] a, input logic [7:0] e,
                         input logic e_err);
        apb(1'b0, a, 32'h0000_0000);
        chk(name, {24'h00_0000, e}, rd);
        chk("read error", e_err, err);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watches instance i for two column periods against its configuration
    task automatic observe(input int i, input logic [7:0] bus, input logic swap,
                           input logic hold);
        logic drive, cmp, nul, p1, p2, prev_two, prev_val;
        int conn;
        drive = bus[DRIVE_BIT];
        cmp = bus[CMP_BIT];
        nul = bus[NULL_BIT];
        conn = 0;
        prev_two = 1'b0;
        prev_val = 1'b0;
        repeat (2) @(posedge mclk);
        chk("c size", thermo(int'(bus[CAP_MSB:0])), sw_ctrl[i].c_cap_en);
        chk("null state", nul, sw_ctrl[i].offset_null_state);
        for (int c = 0; c < 16; c++) begin
            @(posedge mclk);
            p1 = sw_ctrl[i].phase_one;
            p2 = sw_ctrl[i].phase_two;
            chk("phase overlap", 1'b0, p1 & p2);
            chk("phase steer", swap ? sw_ctrl[1].phase_two : sw_ctrl[1].phase_one, p1);
            if (!drive) chk("column float", 1'b0, sw_ctrl[i].column_bus_connect);
            else if (swap) chk("column steady", 1'b1, sw_ctrl[i].column_bus_connect);
            else if (hold) chk("column bypass", p2, sw_ctrl[i].column_bus_connect);
            else chk("column late", 1'b0, sw_ctrl[i].column_bus_connect & ~(p2 & prev_two));
            conn += int'(sw_ctrl[i].column_bus_connect);
            chk("feedback short", nul & p1, sw_ctrl[i].feedback_short);
            chk("branch ground", nul & p1, sw_ctrl[i].branch_to_ground);
            chk("branch opamp", 1'b1, sw_ctrl[i].branch_to_opamp | (nul & ~p2));
            chk("comparator drive", cmp, sw_ctrl[i].comparator_drive);
            if (!cmp) chk("comparator idle", 1'b0, comparator_bus);
            if (!cmp) chk("comparator value", 1'b0, sw_ctrl[i].comparator_value);
            if (cmp) chk("comparator bus", sw_ctrl[i].comparator_value, comparator_bus);
            if (cmp && p2 && prev_two) chk("comparator hold", prev_val, sw_ctrl[i].comparator_value);
            prev_two = p2;
            prev_val = sw_ctrl[i].comparator_value;
        end
        if (drive && !swap && !hold) chk("column late count", 32'd4, conn);
    endtask

    task automatic complete_run();
        if (err_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [7:0] v;
        int size;
        switch_ctrl_s [3:0] snap;
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        for (int i = 0; i < 4; i++) begin
            rdchk("select reset", {SELECT_IDX[i], 2'b00}, 8'h00, 1'b0);
            rdchk("bus reset", {BUS_IDX[i], 2'b00}, 8'h00, 1'b0);
        end
        // Every select code, spread over the four instances
        for (int code = 0; code < 8; code++) begin
            size = (code == 7) ? 31 : code * 4;
            v = {3'(code), 5'(size)};
            wr({SELECT_IDX[code % 4], 2'b00}, v);
            rdchk("select readback", {SELECT_IDX[code % 4], 2'b00}, v, 1'b0);
            repeat (2) @(posedge mclk);
            chk("common source", v[7], sw_ctrl[code % 4].common_source);
            chk("a source", (code < 4) ? v[6:5] : 2'b00, sw_ctrl[code % 4].a_source);
            chk("b size", thermo(size), sw_ctrl[code % 4].b_cap_en);
        end
        // Refused accesses leave state alone
        rdchk("unmapped read", 10'h3fc, 8'h00, 1'b1);
        apb(1'b1, 10'h3fc, 32'h0000_00ff);
        chk("unmapped write error", 1'b1, err);
        rdchk("misaligned read", 10'h205, 8'h00, 1'b1);
        pstrb <= 4'h0;
        apb(1'b1, {SELECT_IDX[3], 2'b00}, 32'h0000_00aa);
        pstrb <= 4'hf;
        rdchk("masked write", {SELECT_IDX[3], 2'b00}, 8'hff, 1'b0);
        // Drive, swap, bypass, comparator and nulling modes on instance 0
        for (int r = 0; r < 4; r++) begin
            wr({PHASE_IDX[0], 2'b00}, {1'b0, r == 2, 6'h00});
            wr({HOLD_BYPASS_IDX, 2'b00}, {1'b0, r == 3, 6'h00});
            wr({BUS_IDX[0], 2'b00}, bus_tab[r]);
            rdchk("bus readback", {BUS_IDX[0], 2'b00}, bus_tab[r], 1'b0);
            observe(0, bus_tab[r], r == 2, r == 3);
        end
        // Clock enable low must freeze every switch output, phases included
        @(posedge mclk);
        ce <= 1'b0;
        @(posedge mclk);
        snap = sw_ctrl;
        repeat (6) @(posedge mclk);
        chk("ce freeze", 32'h0, {31'h0, sw_ctrl !== snap});
        ce <= 1'b1;
        repeat (2) @(posedge mclk);
        complete_run();
    end

    // Hang guard, far beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        complete_run();
    end
endmodule
`default_nettype wire
